// File: hdl/scq_pkg.sv
// scq_pkg: register map, field layout, reset values and encodings for the
// state clock qualifier.
// assumes: APB with 32-bit data, one aligned word per register.
package scq_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_LINES = 6;
   localparam int CNT_W = 3;
   localparam int EVT_W = 16;

   // register byte offsets
   localparam logic [ADDR_W-1:0] CFG_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] QUAL_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] SW_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0c;

   // config register fields
   localparam int CFG_USER_QUAL = 0;
   localparam int CFG_FALL = 1;
   localparam int CFG_USER_SYN = 2;
   localparam int CFG_DIVIDE = 3;
   localparam int CFG_CNT_LO = 4;
   localparam int CFG_W = 7;

   // per-line condition codes, two bits each
   localparam logic [1:0] COND_LOW = 2'h0;
   localparam logic [1:0] COND_HIGH = 2'h1;
   localparam logic [1:0] COND_DC = 2'h2;

   // line positions inside the six qualifier control lines
   localparam int SYNC_A_POS = 2;
   localparam int WAIT_A_POS = 3;
   localparam int SYNC_B_POS = 4;
   localparam int WAIT_B_POS = 5;

   // status register fields
   localparam int ST_INVALID = 0;
   localparam int ST_WAIT = 1;
   localparam int ST_PEND = 2;
   localparam int ST_EVT_LO = 16;

   // reset values: standard qualification, rising edge, standard synthesis
   localparam logic [CFG_W-1:0] CFG_RST = 7'h10;
   localparam logic [2*NUM_LINES-1:0] QUAL_RST = 12'haaa;
   localparam logic [7:0] SW_RST = 8'haa;

   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_MAX = 3'h4;
endpackage : scq_pkg

// File: hdl/scq_line_match.sv
// scq_line_match: tests a group of control lines against two-bit
// conditions (low, high, don't care).
// assumes: lines already synchronous to the block clock.
`timescale 1ns/1ps
module scq_line_match #(
   parameter int N = 2
) (
   input wire logic [N-1:0] lines,
   input wire logic [2*N-1:0] cond,
   output logic all_ok,
   output logic any_hit,
   output logic any_cared
);
   logic [N-1:0] hit;
   logic [N-1:0] cared;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_line
         assign cared[i] = (cond[2*i+1] == 1'b0);
         assign hit[i] = cared[i] && (lines[i] == cond[2*i]);
      end
   endgenerate

   // don't care lines pass the AND and drop out of the OR
   assign all_ok = &(hit | ~cared);
   assign any_hit = |hit;
   assign any_cared = |cared;
endmodule : scq_line_match

// File: hdl/scq_qualifier.sv
// scq_qualifier: builds the state (storage) clock strobe from the target
// master clock, its qualifier lines and optional strobe synthesis.
// assumes: MCLK and CTL are synchronous to CLK and much slower than it;
// one configuration set serves both the main and the timing sections.
//
// Overview of operation
// - sample only on master edges, some skipped
// - edge select: 0 rising, 1 falling
// - AND of six qualifier lines gates edges
// - no user qualification means default settings
// - standard synthesis passes qualified clock unchanged
// - delay mode strobes 0..4 edges after sync
// - delay mode: one strobe per sync assertion
// - divide by 1..4, restarted by sync
// - sync is OR of two coded lines
// - delay with sync don't care: no strobe
// - divide with sync don't care flagged invalid
// - wait is OR of two coded lines
// - each wait cycle stretches synthesized cycle one edge
// - sync suspended while wait asserted
// - settings persist until software rewrites them
// - one configuration shared by both sections
`timescale 1ns/1ps
module scq_qualifier #(
   parameter int ADDR_W = scq_pkg::ADDR_W,
   parameter int EVT_W = scq_pkg::EVT_W
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [scq_pkg::DATA_W-1:0] PWDATA,
   output logic [scq_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic MCLK,
   input wire logic [scq_pkg::NUM_LINES-1:0] CTL,
   output logic STATE_STROBE,
   output logic CFG_INVALID
);
   localparam int CW = scq_pkg::CNT_W;
   // sync and wait groups: two lines, two code bits each
   localparam int GRP_W = 4;
   localparam int SW_W = 2 * GRP_W;

   // clamp the shared count field to its legal range
   function automatic logic [CW-1:0] clamp_cnt(input logic [CW-1:0] v,
                                               input logic lo_one);
      logic [CW-1:0] r;
      r = v;
      if (v > scq_pkg::CNT_MAX) begin
         r = scq_pkg::CNT_MAX;
      end else if (lo_one && v == scq_pkg::CNT_ZERO) begin
         r = scq_pkg::CNT_ONE;
      end
      return r;
   endfunction : clamp_cnt

   // register file
   logic [scq_pkg::CFG_W-1:0] cfg_q;
   logic [2*scq_pkg::NUM_LINES-1:0] qual_q;
   logic [SW_W-1:0] sw_q;
   logic pready_q;
   logic [scq_pkg::DATA_W-1:0] prdata_q;
   logic pslverr_q;

   wire access = PSEL && PENABLE;
   wire start_ans = access && !pready_q;
   wire hit_cfg = (PADDR == scq_pkg::CFG_OFS);
   wire hit_qual = (PADDR == scq_pkg::QUAL_OFS);
   wire hit_sw = (PADDR == scq_pkg::SW_OFS);
   wire hit_stat = (PADDR == scq_pkg::STAT_OFS);
   wire mapped = hit_cfg || hit_qual || hit_sw || hit_stat;
   wire wr_done = access && pready_q && PWRITE;

   // decoded settings
   wire user_qual = cfg_q[scq_pkg::CFG_USER_QUAL];
   wire user_syn = cfg_q[scq_pkg::CFG_USER_SYN];
   wire mode_div = cfg_q[scq_pkg::CFG_DIVIDE];
   wire [CW-1:0] cnt_raw = cfg_q[scq_pkg::CFG_CNT_LO +: CW];
   wire [CW-1:0] delay_n = clamp_cnt(cnt_raw, 1'b0);
   wire [CW-1:0] div_n = clamp_cnt(cnt_raw, 1'b1);
   wire eff_fall = user_qual && cfg_q[scq_pkg::CFG_FALL];

   // master edge detection
   logic mclk_q;
   wire rise = MCLK && !mclk_q;
   wire fall = !MCLK && mclk_q;
   wire act_edge = eff_fall ? fall : rise;

   // line evaluation
   logic and_ok;
   logic sync_now;
   logic sync_cared;
   logic wait_now;
   logic [1:0] sync_lines;
   logic [1:0] wait_lines;

   assign sync_lines = {CTL[scq_pkg::SYNC_B_POS], CTL[scq_pkg::SYNC_A_POS]};
   assign wait_lines = {CTL[scq_pkg::WAIT_B_POS], CTL[scq_pkg::WAIT_A_POS]};

   scq_line_match #(.N(scq_pkg::NUM_LINES)) u_and (
      .lines(CTL),
      .cond(qual_q),
      .all_ok(and_ok),
      .any_hit(),
      .any_cared()
   );

   scq_line_match #(.N(2)) u_sync (
      .lines(sync_lines),
      .cond(sw_q[GRP_W-1:0]),
      .all_ok(),
      .any_hit(sync_now),
      .any_cared(sync_cared)
   );

   scq_line_match #(.N(2)) u_wait (
      .lines(wait_lines),
      .cond(sw_q[SW_W-1:GRP_W]),
      .all_ok(),
      .any_hit(wait_now),
      .any_cared()
   );

   wire qual_edge = act_edge && (!user_qual || and_ok);

   // strobe synthesis
   logic sync_prev_q;
   logic pend_q;
   logic [CW-1:0] rem_q;
   logic [CW-1:0] phase_q;
   logic strobe_q;
   logic invalid_q;
   logic wait_q;
   logic [EVT_W-1:0] evt_q;

   wire sync_start = qual_edge && !wait_now && sync_now && !sync_prev_q;
   wire syn_step = qual_edge && !wait_now;
   wire delay_mode = user_syn && !mode_div;
   wire div_mode = user_syn && mode_div;

   // one strobe per sync, after delay_n edges
   wire dly_now0 = sync_start && delay_n == scq_pkg::CNT_ZERO;
   wire dly_fire = syn_step && pend_q && !sync_start &&
                   rem_q == scq_pkg::CNT_ONE;
   wire dly_strobe = dly_now0 || dly_fire;
   wire pend_d = sync_start ? (delay_n != scq_pkg::CNT_ZERO) :
                 (dly_fire ? 1'b0 : pend_q);
   wire [CW-1:0] rem_d = sync_start ? delay_n :
                 ((syn_step && pend_q) ? rem_q - scq_pkg::CNT_ONE : rem_q);

   // every Nth edge, restarted by sync
   wire [CW-1:0] phase_inc = phase_q + scq_pkg::CNT_ONE;
   wire div_wrap = phase_inc >= div_n;
   wire div_strobe = syn_step && (sync_start || div_wrap);
   wire [CW-1:0] phase_d = !syn_step ? phase_q :
                 ((sync_start || div_wrap) ? scq_pkg::CNT_ZERO : phase_inc);

   // wait holds synthesis; in delay mode no sync means no strobe
   wire strobe_d = !user_syn ? qual_edge :
                   (mode_div ? div_strobe : dly_strobe);
   // divide with sync all don't care
   wire invalid_d = div_mode && !sync_cared;
   // running strobe count for status
   wire [EVT_W-1:0] evt_d = evt_q + {{(EVT_W-1){1'b0}}, strobe_d};

   always_ff @(posedge CLK) begin
      if (RST) begin
         mclk_q <= 1'b0;
         sync_prev_q <= 1'b0;
         pend_q <= 1'b0;
         rem_q <= scq_pkg::CNT_ZERO;
         phase_q <= scq_pkg::CNT_ZERO;
         strobe_q <= 1'b0;
         invalid_q <= 1'b0;
         wait_q <= 1'b0;
         evt_q <= '0;
      end else begin
         mclk_q <= MCLK;
         if (syn_step) begin
            sync_prev_q <= sync_now;
         end
         pend_q <= delay_mode && pend_d;
         rem_q <= rem_d;
         phase_q <= phase_d;
         strobe_q <= strobe_d;
         invalid_q <= invalid_d;
         if (qual_edge) begin
            wait_q <= wait_now;
         end
         evt_q <= evt_d;
      end
   end

   // APB slave; status fields at their named positions
   logic [scq_pkg::DATA_W-1:0] stat_word;
   always_comb begin
      stat_word = '0;
      stat_word[scq_pkg::ST_INVALID] = invalid_q;
      stat_word[scq_pkg::ST_WAIT] = wait_q;
      stat_word[scq_pkg::ST_PEND] = pend_q;
      stat_word[scq_pkg::ST_EVT_LO +: EVT_W] = evt_q;
   end
   wire [scq_pkg::DATA_W-1:0] rd_mux =
      hit_cfg ? {{(scq_pkg::DATA_W-scq_pkg::CFG_W){1'b0}}, cfg_q} :
      hit_qual ? {{(scq_pkg::DATA_W-2*scq_pkg::NUM_LINES){1'b0}}, qual_q} :
      hit_sw ? {{(scq_pkg::DATA_W-SW_W){1'b0}}, sw_q} :
      hit_stat ? stat_word : '0;

   always_ff @(posedge CLK) begin
      if (RST) begin
         cfg_q <= scq_pkg::CFG_RST;
         qual_q <= scq_pkg::QUAL_RST;
         sw_q <= scq_pkg::SW_RST;
         pready_q <= 1'b0;
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= start_ans;
         if (start_ans) begin
            prdata_q <= PWRITE ? '0 : rd_mux;
            pslverr_q <= !mapped;
         end else begin
            pslverr_q <= 1'b0;
         end
         if (wr_done && hit_cfg) begin
            cfg_q <= PWDATA[scq_pkg::CFG_W-1:0];
         end
         if (wr_done && hit_qual) begin
            qual_q <= PWDATA[2*scq_pkg::NUM_LINES-1:0];
         end
         if (wr_done && hit_sw) begin
            sw_q <= PWDATA[SW_W-1:0];
         end
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign STATE_STROBE = strobe_q;
   assign CFG_INVALID = invalid_q;

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   strobe_master_a: assert property (
      STATE_STROBE |-> $past(qual_edge))
      else $error("strobe without a qualified master edge");

   edge_sel_a: assert property (
      qual_edge |-> (eff_fall ? (!MCLK && mclk_q) : (MCLK && !mclk_q)))
      else $error("qualified edge has wrong polarity");

   and_gate_a: assert property (
      (user_qual && act_edge && !and_ok) |=> !STATE_STROBE)
      else $error("edge passed with qualifier AND false");

   default_qual_a: assert property (
      (!user_qual && MCLK && !mclk_q) |-> qual_edge)
      else $error("default qualification dropped a rising edge");

   std_pass_a: assert property (
      !user_syn |-> ##1 (STATE_STROBE == $past(qual_edge)))
      else $error("standard synthesis altered the clock");

   delay_zero_a: assert property (
      (delay_mode && delay_n == scq_pkg::CNT_ZERO && sync_start)
      |=> STATE_STROBE)
      else $error("zero delay did not strobe at sync");

   dc_delay_a: assert property (
      (delay_mode && !sync_cared && !pend_q) |=> !STATE_STROBE)
      else $error("strobe with sync lines all don't care");

   wait_hold_a: assert property (
      (user_syn && wait_now && qual_edge) |=> !STATE_STROBE)
      else $error("strobe on a wait cycle");

   invalid_flag_a: assert property (
      (div_mode && !sync_cared) |=> CFG_INVALID)
      else $error("unusable divide setup not flagged");

   invalid_clear_a: assert property (
      (!div_mode || sync_cared) |=> !CFG_INVALID)
      else $error("usable setup flagged invalid");

   strobe_gap_a: assert property (
      STATE_STROBE |=> !STATE_STROBE)
      else $error("strobe held for two cycles");

   delay_once_a: assert property (
      (delay_mode && !pend_q && !sync_start) |=> !STATE_STROBE)
      else $error("delay strobe without a sync assertion");

   delay_pend_a: assert property (
      (delay_mode && sync_start && delay_n != scq_pkg::CNT_ZERO) |=> pend_q)
      else $error("nonzero delay did not arm at sync");

   div_sync_a: assert property (
      (div_mode && sync_start) |=> STATE_STROBE)
      else $error("divide did not strobe at sync");

   div_one_a: assert property (
      (div_mode && div_n == scq_pkg::CNT_ONE && syn_step) |=> STATE_STROBE)
      else $error("divide by one skipped an edge");

   wait_sync_a: assert property (
      (delay_mode && wait_now && !pend_q) |=> !pend_q)
      else $error("sync during wait started a delay");

   wait_delay_a: assert property (
      (delay_mode && pend_q && wait_now && qual_edge) |=> $stable(rem_q))
      else $error("wait cycle advanced the delay");

   reset_cfg_a: assert property (
      $fell(RST) |-> (cfg_q == scq_pkg::CFG_RST &&
         qual_q == scq_pkg::QUAL_RST && sw_q == scq_pkg::SW_RST))
      else $error("settings not at defaults after reset");

   settings_hold_a: assert property (
      !(PSEL && PENABLE && PWRITE && PREADY) |=>
         $stable({cfg_q, qual_q, sw_q}))
      else $error("settings changed without a write");

   apb_err_a: assert property (
      (access && !pready_q && !mapped) |=> (PREADY && PSLVERR))
      else $error("unmapped access without error");

   apb_ready_a: assert property (
      (access && !pready_q) |=> (PREADY ##1 !PREADY))
      else $error("ready not one cycle after access");
endmodule : scq_qualifier

// File: verif/scq_sut_model.sv
// scq_sut_model: target side, makes master clock bursts and control lines.
// assumes: bench pulses start with a cycle count, half period and levels;
// the master clock stands still low between bursts.
`timescale 1ns/1ps
module scq_sut_model (
   input wire logic clk,
   input wire logic start,
   input wire logic [7:0] cycles,
   input wire logic [2:0] half,
   input wire logic [5:0] ctl_in,
   output logic mclk,
   output logic [5:0] ctl,
   output logic busy
);
   logic [8:0] edges_q = 9'h000;
   logic [2:0] tick_q = 3'h0;
   logic mclk_q = 1'b0;
   logic [5:0] ctl_q = 6'h00;
   logic busy_q = 1'b0;
   assign mclk = mclk_q;
   assign ctl = ctl_q;
   assign busy = busy_q;
   // control levels held for a whole burst
   always @(posedge clk) begin
      if (start && !busy_q) begin
         busy_q <= 1'b1;
         edges_q <= {cycles, 1'b0};
         ctl_q <= ctl_in;
         tick_q <= half;
      end else if (busy_q) begin
         if (tick_q > 3'h1) begin
            tick_q <= tick_q - 3'h1;
         end else if (edges_q == 9'h000) begin
            busy_q <= 1'b0;
         end else begin
            mclk_q <= ~mclk_q;
            edges_q <= edges_q - 9'h001;
            tick_q <= half;
         end
      end
   end
endmodule : scq_sut_model

// File: verif/scq_qualifier_tb_top.sv
// scq_qualifier_tb_top: self-checking bench for the state clock qualifier.
// assumes: scq_sut_model drives MCLK and CTL; tasks below master APB.
`timescale 1ns/1ps
module scq_qualifier_tb_top;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic PREADY, PSLVERR, MCLK, STATE_STROBE, CFG_INVALID, ms_busy;
   logic [5:0] CTL, ms_ctl = 6'h00;
   logic ms_go = 1'b0, lvl = 1'b1;
   logic [7:0] ms_n = 8'h00;
   logic [2:0] ms_half = 3'h5;
   logic [31:0] lf = 32'h9bd561b9;
   logic [32:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [15:0] cnt = 16'h0, strb_n = 16'h0;
   int bad_count = 0, total_checks = 0;
   always #25 CLK = ~CLK;
   scq_qualifier dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .MCLK(MCLK), .CTL(CTL),
      .STATE_STROBE(STATE_STROBE), .CFG_INVALID(CFG_INVALID));
   scq_sut_model sut (.clk(CLK), .start(ms_go), .cycles(ms_n),
      .half(ms_half), .ctl_in(ms_ctl), .mclk(MCLK), .ctl(CTL),
      .busy(ms_busy));
   function automatic logic [31:0] lf_nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lf_nx
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [32:0] s, input logic [32:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [31:0] m, input logic e);
      int n;
      n = 0;
      exp_q.push_back({e, d & m});
      msk_q.push_back(m);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n >= 20) begin
         bad_count++;
         stop_test();
      end
      @(posedge CLK);
   endtask : apb
   task automatic cfg(input logic [31:0] c, input logic [31:0] q,
         input logic [31:0] s);
      apb(1'b1, scq_pkg::CFG_OFS, c, 32'h0, 1'b0);
      apb(1'b1, scq_pkg::QUAL_OFS, q, 32'h0, 1'b0);
      apb(1'b1, scq_pkg::SW_OFS, s, 32'h0, 1'b0);
      repeat (2) @(posedge CLK);
   endtask : cfg
   // one burst of n master cycles; lines outside mask c are random
   task automatic run(input logic [7:0] n, input logic [5:0] v,
         input logic [5:0] c);
      int k;
      k = 0;
      lf = lf_nx(lf);
      ms_n <= n;
      ms_half <= lf[0] ? 3'h5 : 3'h6;
      ms_ctl <= (lf[7:2] & ~c) | (v & c);
      ms_go <= 1'b1;
      @(posedge CLK);
      ms_go <= 1'b0;
      @(posedge CLK);
      while (ms_busy === 1'b1 && k < 300) begin
         @(posedge CLK);
         k++;
      end
      if (k >= 300) begin
         bad_count++;
         stop_test();
      end
      repeat (4) @(posedge CLK);
   endtask : run
   task automatic tally(input logic [15:0] n);
      cnt = cnt + n;
      chk({17'h0, strb_n}, {17'h0, cnt});
      apb(1'b0, scq_pkg::STAT_OFS, {cnt, 16'h0}, 32'hffff0000, 1'b0);
   endtask : tally
   // results: read answers in order, strobes at the chosen level
   always @(posedge CLK) begin
      if (PSEL && PENABLE && PREADY === 1'b1 && exp_q.size() > 0) begin
         chk({PSLVERR, PRDATA & msk_q[0]}, exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      if (STATE_STROBE === 1'b1) begin
         strb_n <= strb_n + 16'h1;
         chk({32'h0, MCLK}, {32'h0, lvl});
      end
   end
   initial begin
      int i;
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      apb(1'b0, scq_pkg::CFG_OFS, 32'h10, 32'hffffffff, 1'b0);
      apb(1'b0, scq_pkg::QUAL_OFS, 32'haaa, 32'hffffffff, 1'b0);
      apb(1'b0, scq_pkg::SW_OFS, 32'haa, 32'hffffffff, 1'b0);
      apb(1'b0, 8'h10, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, scq_pkg::STAT_OFS, 32'hffffffff, 32'h0, 1'b0);
      apb(1'b0, scq_pkg::STAT_OFS, 32'h0, 32'hffffffff, 1'b0);
      run(8'h8, 6'h0, 6'h0);
      tally(16'h8);
      cfg(32'h2, 32'haa1, 32'haa);
      run(8'h4, 6'h2, 6'h3);
      tally(16'h4);
      cfg(32'h1, 32'haa1, 32'haa);
      for (i = 0; i < 4; i++) begin
         run(8'h3, 6'(i), 6'h3);
         tally((i == 1) ? 16'h3 : 16'h0);
      end
      lvl = 1'b0;
      cfg(32'h3, 32'haa1, 32'haa);
      run(8'h4, 6'h1, 6'h3);
      tally(16'h4);
      lvl = 1'b1;
      cfg(32'h28, 32'haaa, 32'ha9);
      run(8'h4, 6'h0, 6'h4);
      tally(16'h4);
      for (i = 0; i < 5; i++) begin
         cfg(32'h4 | (32'(i) << 4), 32'haaa, 32'ha9);
         run(8'h1, 6'h4, 6'h4);
         apb(1'b0, scq_pkg::STAT_OFS, (i > 0) ? 32'h4 : 32'h0, 32'h4, 1'b0);
         if (i > 0) run(8'(i - 1), 6'h0, 6'h4);
         tally((i == 0) ? 16'h1 : 16'h0);
         run(8'h4, 6'h0, 6'h4);
         tally((i == 0) ? 16'h0 : 16'h1);
      end
      // sync is the OR of both lines
      cfg(32'h4, 32'haaa, 32'ha1);
      run(8'h1, 6'h10, 6'h14);
      run(8'h1, 6'h00, 6'h14);
      run(8'h1, 6'h04, 6'h14);
      run(8'h1, 6'h10, 6'h14);
      run(8'h1, 6'h14, 6'h14);
      tally(16'h2);
      cfg(32'h4, 32'haaa, 32'haa);
      run(8'h4, 6'h4, 6'h0);
      tally(16'h0);
      for (i = 1; i < 5; i++) begin
         cfg(32'hc | (32'(i) << 4), 32'haaa, 32'ha9);
         chk({32'h0, CFG_INVALID}, 33'h0);
         run(8'h1, 6'h4, 6'h4);
         run(8'h8, 6'h0, 6'h4);
         tally(16'(1 + 8 / i));
      end
      cfg(32'h2c, 32'haaa, 32'haa);
      chk({32'h0, CFG_INVALID}, 33'h1);
      apb(1'b0, scq_pkg::STAT_OFS, 32'h1, 32'h1, 1'b0);
      cfg(32'h2c, 32'haaa, 32'h99);
      run(8'h1, 6'h4, 6'hc);
      run(8'h1, 6'h8, 6'hc);
      apb(1'b0, scq_pkg::STAT_OFS, 32'h2, 32'h2, 1'b0);
      run(8'h3, 6'h0, 6'hc);
      tally(16'h2);
      cfg(32'h4c, 32'haaa, 32'h29);
      run(8'h1, 6'h24, 6'h24);
      run(8'h1, 6'h20, 6'h24);
      run(8'h1, 6'h04, 6'h24);
      apb(1'b0, scq_pkg::STAT_OFS, 32'h2, 32'h2, 1'b0);
      run(8'h3, 6'h20, 6'h24);
      tally(16'h2);
      stop_test();
   end
endmodule : scq_qualifier_tb_top
